// [rtl/msp_serial_port.sv]
// Multibuffered serial port with APB registers and buffer memory
// How it works
// - Word length programmable from 2 to 16
// - Shifts out and in at once
// - Bit rate from 8-bit baud divisor
// - Master drives clock, slave follows external clock
// - Each buffer entry carries its own format
// - Unused serial pins become software-driven GPIO
// - Buffer memory holds 256 entries
// - Entry fields: transmit, receive, control, status
// - Software picks group range of entries
// - Select-to-clock wait is delay plus two/three
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
module msp_serial_port import msp_pkg::*; (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [12:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial clock pin
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    // Master-out slave-in pin
    input  wire logic        simo_in,
    output logic             simo_out,
    output logic             simo_oe,
    // Master-in slave-out pin
    input  wire logic        somi_in,
    output logic             somi_out,
    output logic             somi_oe,
    // Chip select pin, active low
    input  wire logic        cs_n_in,
    output logic             cs_n_out,
    output logic             cs_n_oe
);
    function automatic logic hit(input logic [12:0] a, input logic [12:0] off);
        hit = (a == off);
    endfunction : hit

    msp_state_t     state_reg;
    logic           en_reg, master_reg, hold_reg, done_reg, ack_reg, ram_rd_reg;
    logic [7:0]     baud_reg, delay_reg, first_reg, last_reg, idx_reg, div_reg;
    logic [3:0]     gsel_reg, gout_reg, goe_reg;
    logic [31:0]    prdata_reg;
    logic [1:0]     fld_reg;
    logic [4:0]     len_reg, edge_reg;
    logic [8:0]     wait_reg;
    logic           cpol_reg, cpha_reg, sclk_reg, clk_prev_reg, sout_reg, cs_n_reg;
    logic [15:0]    tx_sh_reg, rx_sh_reg, rx_buf_reg, tx_word, ctl_word;
    logic [63:0]    a_rdata, b_rdata, b_wdata;
    logic [3:0]     a_we, b_we, pin_in, fn_out, fn_oe;
    logic           acc, wr_fire, is_ram, mapped, start, tick, edge_ev, leading;
    logic           sample_ev, launch_ev, last_edge, slave_act;
    logic [4:0]     len_next;

    // APB: every transfer has one wait state
    assign acc     = psel & penable;
    assign pready  = ack_reg;
    assign wr_fire = acc & pwrite & ack_reg;
    assign is_ram  = paddr[RAM_SEL_BIT];
    assign mapped  = is_ram | hit(paddr, OFF_CTRL) | hit(paddr, OFF_BAUD) |
                     hit(paddr, OFF_DELAY) | hit(paddr, OFF_GROUP) |
                     hit(paddr, OFF_STATUS) | hit(paddr, OFF_GIO) | hit(paddr, OFF_GIN);
    assign pslverr = ack_reg & ~mapped;
    assign prdata  = ram_rd_reg ? {16'h0000, a_rdata[fld_reg*FLD_W +: FLD_W]} : prdata_reg;
    assign start   = wr_fire & hit(paddr, OFF_CTRL) & pwdata[CTRL_START] & pwdata[CTRL_EN];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg    <= 1'b0;
            ram_rd_reg <= 1'b0;
            fld_reg    <= 2'h0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg    <= acc & ~ack_reg;
            ram_rd_reg <= acc & ~ack_reg & is_ram & ~pwrite;
            fld_reg    <= paddr[RAM_FLD_LSB +: 2];
            prdata_reg <= 32'h0000_0000;
            if (acc && !ack_reg && !pwrite) begin
                if (hit(paddr, OFF_CTRL)) begin
                    prdata_reg <= {29'h0, hold_reg, master_reg, en_reg};
                end else if (hit(paddr, OFF_BAUD)) begin
                    prdata_reg <= {24'h0, baud_reg};
                end else if (hit(paddr, OFF_DELAY)) begin
                    prdata_reg <= {24'h0, delay_reg};
                end else if (hit(paddr, OFF_GROUP)) begin
                    prdata_reg <= {16'h0, last_reg, first_reg};
                end else if (hit(paddr, OFF_STATUS)) begin
                    prdata_reg <= {rx_buf_reg, idx_reg, 6'h0, done_reg, state_reg != ST_IDLE};
                end else if (hit(paddr, OFF_GIO)) begin
                    prdata_reg <= {20'h0, goe_reg, gout_reg, gsel_reg};
                end else if (hit(paddr, OFF_GIN)) begin
                    prdata_reg <= {28'h0, pin_in};
                end
            end
        end
    end

    // Configuration writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg     <= 1'b0;
            master_reg <= 1'b0;
            hold_reg   <= 1'b0;
            baud_reg   <= 8'h00;
            delay_reg  <= 8'h00;
            first_reg  <= 8'h00;
            last_reg   <= 8'h00;
            gsel_reg   <= 4'h0;
            gout_reg   <= 4'h0;
            goe_reg    <= 4'h0;
        end else if (wr_fire) begin
            if (hit(paddr, OFF_CTRL)) begin
                en_reg     <= pwdata[CTRL_EN];
                master_reg <= pwdata[CTRL_MASTER];
                hold_reg   <= pwdata[CTRL_HOLD];
            end else if (hit(paddr, OFF_BAUD)) begin
                baud_reg <= pwdata[7:0];
            end else if (hit(paddr, OFF_DELAY)) begin
                delay_reg <= pwdata[7:0];
            end else if (hit(paddr, OFF_GROUP)) begin
                first_reg <= pwdata[7:0];
                last_reg  <= pwdata[15:8];
            end else if (hit(paddr, OFF_GIO)) begin
                gsel_reg <= pwdata[GIO_SEL +: 4];
                gout_reg <= pwdata[GIO_OUT +: 4];
                goe_reg  <= pwdata[GIO_OE +: 4];
            end
        end
    end

    // Group-done flag; a finishing group beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg <= 1'b0;
        end else if (state_reg == ST_STORE && idx_reg == last_reg) begin
            done_reg <= 1'b1;
        end else if (wr_fire && hit(paddr, OFF_STATUS) && pwdata[STAT_DONE]) begin
            done_reg <= 1'b0;
        end
    end

    always_comb begin
        a_we = 4'h0;
        if (wr_fire && is_ram) begin
            a_we[paddr[RAM_FLD_LSB +: 2]] = 1'b1;
        end
    end
    assign b_we    = (state_reg == ST_STORE) ? 4'b1010 : 4'h0;
    assign b_wdata = {WSTAT_DONE, ctl_word, rx_sh_reg, tx_word};
    assign tx_word  = b_rdata[FLD_TX*FLD_W +: FLD_W];
    assign ctl_word = b_rdata[FLD_CTL*FLD_W +: FLD_W];

    msp_buffer_ram u_ram (
        .pclk    (pclk),
        .a_idx   (paddr[RAM_IDX_LSB +: 8]),
        .a_we    (a_we),
        .a_wdata (pwdata[15:0]),
        .a_rdata (a_rdata),
        .b_idx   (idx_reg),
        .b_we    (b_we),
        .b_wdata (b_wdata),
        .b_rdata (b_rdata)
    );

    assign len_next = ({1'b0, ctl_word[WCTL_LEN +: 4]} + 5'h01 < LEN_MIN) ? LEN_MIN :
                      {1'b0, ctl_word[WCTL_LEN +: 4]} + 5'h01;

    // baud divider, half period is divisor plus one
    // Preset outside shift so the first edge needs no extra half period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 8'h00;
        end else if (state_reg != ST_SHIFT) begin
            div_reg <= baud_reg;
        end else if (div_reg == baud_reg) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign tick = (state_reg == ST_SHIFT) && (div_reg == baud_reg);

    // edge source: own divider as master, pin as slave
    assign slave_act = !master_reg && !cs_n_in && state_reg == ST_SHIFT;
    assign edge_ev   = master_reg ? tick : (slave_act && sclk_in != clk_prev_reg);
    assign leading   = master_reg ? (sclk_reg == cpol_reg) : (clk_prev_reg == cpol_reg);
    assign sample_ev = edge_ev && (leading ^ cpha_reg);
    assign launch_ev = edge_ev && !(leading ^ cpha_reg);
    assign last_edge = edge_ev && (edge_reg == {len_reg[3:0], 1'b0} - 5'h01);

    // Control sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            idx_reg   <= 8'h00;
            wait_reg  <= 9'h000;
            cs_n_reg  <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cs_n_reg <= 1'b1;
                    if (start) begin
                        idx_reg   <= first_reg;
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    state_reg <= ST_FETCH;
                end
                ST_FETCH: begin
                    // select-to-clock wait
                    // One cycle of the wait is the first shift cycle
                    wait_reg  <= {1'b0, delay_reg} + (hold_reg ? SEL_EXTRA_HOLD : SEL_EXTRA)
                                 - 9'h001;
                    cs_n_reg  <= ~master_reg;
                    state_reg <= master_reg ? ST_DELAY : ST_SHIFT;
                end
                ST_DELAY: begin
                    wait_reg <= wait_reg - 9'h001;
                    if (wait_reg == 9'h001) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (!en_reg) begin
                        state_reg <= ST_IDLE;
                    end else if (last_edge) begin
                        state_reg <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    if (idx_reg == last_reg) begin
                        state_reg <= ST_IDLE;
                        cs_n_reg  <= 1'b1;
                    end else begin
                        // Hold keeps select low between words of a group
                        idx_reg   <= idx_reg + 8'h01;
                        cs_n_reg  <= ~(hold_reg & master_reg);
                        state_reg <= ST_LOAD;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // shift path, format taken per entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_reg      <= LEN_MAX;
            cpol_reg     <= 1'b0;
            cpha_reg     <= 1'b0;
            sclk_reg     <= 1'b0;
            clk_prev_reg <= 1'b0;
            edge_reg     <= 5'h00;
            tx_sh_reg    <= 16'h0000;
            rx_sh_reg    <= 16'h0000;
            sout_reg     <= 1'b0;
        end else begin
            clk_prev_reg <= sclk_in;
            if (state_reg == ST_FETCH) begin
                len_reg   <= len_next;
                cpol_reg  <= ctl_word[WCTL_CPOL];
                cpha_reg  <= ctl_word[WCTL_CPHA];
                sclk_reg  <= ctl_word[WCTL_CPOL];
                edge_reg  <= 5'h00;
                rx_sh_reg <= 16'h0000;
                // Left-align word; phase 0 presents first bit now
                if (ctl_word[WCTL_CPHA]) begin
                    tx_sh_reg <= tx_word << (LEN_MAX - len_next);
                end else begin
                    sout_reg  <= tx_word[len_next[3:0] - 4'h1];
                    tx_sh_reg <= tx_word << (LEN_MAX - len_next + 5'h01);
                end
            end else if (edge_ev) begin
                edge_reg <= edge_reg + 5'h01;
                if (master_reg) begin
                    sclk_reg <= ~sclk_reg;
                end
                if (sample_ev) begin
                    rx_sh_reg <= {rx_sh_reg[14:0], master_reg ? somi_in : simo_in};
                end
                if (launch_ev) begin
                    sout_reg  <= tx_sh_reg[15];
                    tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_reg <= 16'h0000;
        end else if (state_reg == ST_STORE) begin
            rx_buf_reg <= rx_sh_reg;
        end
    end

    // Functional pin drive per role
    assign pin_in = {cs_n_in, somi_in, simo_in, sclk_in};
    assign fn_out = {cs_n_reg, sout_reg, sout_reg, sclk_reg};
    assign fn_oe  = master_reg ? {en_reg, 1'b0, en_reg, en_reg} :
                                 {1'b0, en_reg & ~cs_n_in, 1'b0, 1'b0};

    // pins handed to software when selected
    logic [3:0] pin_out, pin_oe;
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_pin
            assign pin_out[p] = gsel_reg[p] ? gout_reg[p] : fn_out[p];
            assign pin_oe[p]  = gsel_reg[p] ? goe_reg[p] : fn_oe[p];
        end
    endgenerate
    assign sclk_out = pin_out[PIN_CLK];
    assign sclk_oe  = pin_oe[PIN_CLK];
    assign simo_out = pin_out[PIN_SIMO];
    assign simo_oe  = pin_oe[PIN_SIMO];
    assign somi_out = pin_out[PIN_SOMI];
    assign somi_oe  = pin_oe[PIN_SOMI];
    assign cs_n_out = pin_out[PIN_CS];
    assign cs_n_oe  = pin_oe[PIN_CS];
endmodule : msp_serial_port

// [rtl/msp_pkg.sv]
// Constants shared by the multibuffered serial port files
package msp_pkg;
    // Register byte offsets
    localparam logic [12:0] OFF_CTRL   = 13'h0000;
    localparam logic [12:0] OFF_BAUD   = 13'h0004;
    localparam logic [12:0] OFF_DELAY  = 13'h0008;
    localparam logic [12:0] OFF_GROUP  = 13'h000c;
    localparam logic [12:0] OFF_STATUS = 13'h0010;
    localparam logic [12:0] OFF_GIO    = 13'h0014;
    localparam logic [12:0] OFF_GIN    = 13'h0018;
    // Buffer window: bit 12 set, entry in [11:4], field in [3:2]
    localparam int RAM_SEL_BIT = 12;
    localparam int RAM_IDX_LSB = 4;
    localparam int RAM_FLD_LSB = 2;
    // Control register bits
    localparam int CTRL_EN     = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_HOLD   = 2;
    localparam int CTRL_START  = 3;
    // Status register bits
    localparam int STAT_BUSY   = 0;
    localparam int STAT_DONE   = 1;
    localparam int STAT_IDX    = 8;
    // General purpose pin register fields
    localparam int GIO_SEL     = 0;
    localparam int GIO_OUT     = 4;
    localparam int GIO_OE      = 8;
    // Pin order in the pin vectors
    localparam int PIN_CLK  = 0;
    localparam int PIN_SIMO = 1;
    localparam int PIN_SOMI = 2;
    localparam int PIN_CS   = 3;
    // Buffer entry: four 16-bit fields
    localparam int ENTRIES  = 256;
    localparam int FLD_W    = 16;
    localparam int NFLD     = 4;
    localparam int FLD_TX   = 0;
    localparam int FLD_RX   = 1;
    localparam int FLD_CTL  = 2;
    localparam int FLD_STAT = 3;
    // Per-word control field: length minus one, polarity, phase
    localparam int WCTL_LEN  = 0;
    localparam int WCTL_CPOL = 4;
    localparam int WCTL_CPHA = 5;
    localparam logic [4:0] LEN_MIN = 5'h02;
    localparam logic [4:0] LEN_MAX = 5'h10;
    // Extra select-to-clock cycles without and with hold
    localparam logic [8:0] SEL_EXTRA      = 9'h002;
    localparam logic [8:0] SEL_EXTRA_HOLD = 9'h003;
    localparam logic [15:0] WSTAT_DONE = 16'h0001;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_LOAD  = 6'b000010,
        ST_FETCH = 6'b000100,
        ST_DELAY = 6'b001000,
        ST_SHIFT = 6'b010000,
        ST_STORE = 6'b100000
    } msp_state_t;
endpackage : msp_pkg

// [rtl/msp_buffer_ram.sv]
// Dual-port buffer memory with four 16-bit fields per entry
`timescale 1ns/100ps
module msp_buffer_ram import msp_pkg::*; (
    // Clock
    input  wire logic                  pclk,
    // Bus port
    input  wire logic [7:0]            a_idx,
    input  wire logic [NFLD-1:0]       a_we,
    input  wire logic [FLD_W-1:0]      a_wdata,
    output logic [NFLD*FLD_W-1:0]      a_rdata,
    // Engine port
    input  wire logic [7:0]            b_idx,
    input  wire logic [NFLD-1:0]       b_we,
    input  wire logic [NFLD*FLD_W-1:0] b_wdata,
    output logic [NFLD*FLD_W-1:0]      b_rdata
);
    genvar f;
    generate
        for (f = 0; f < NFLD; f = f + 1) begin : g_fld
            logic [FLD_W-1:0] mem [ENTRIES];
            // Engine write placed last so it wins a same-entry clash
            always_ff @(posedge pclk) begin
                if (a_we[f]) begin
                    mem[a_idx] <= a_wdata;
                end
                if (b_we[f]) begin
                    mem[b_idx] <= b_wdata[f*FLD_W +: FLD_W];
                end
                a_rdata[f*FLD_W +: FLD_W] <= mem[a_idx];
                b_rdata[f*FLD_W +: FLD_W] <= mem[b_idx];
            end
        end
    endgenerate
endmodule : msp_buffer_ram

// [tb/msp_properties.sv]
// Checker for the serial port's bus and pin timing
`timescale 1ns/100ps
module msp_properties (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        sclk_out,
    input wire logic        sclk_oe,
    input wire logic        simo_oe,
    input wire logic        somi_oe,
    input wire logic        cs_n_out,
    input wire logic        cs_n_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       sclk_prev;
    logic [6:0] edges;
    // Toggles while selected; saturates so a stuck select cannot wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev <= 1'b0;
            edges     <= 7'h00;
        end else begin
            sclk_prev <= sclk_out;
            if (cs_n_out)
                edges <= 7'h00;
            else if (sclk_out != sclk_prev && edges != 7'h7f)
                edges <= edges + 7'h01;
        end
    end
    chk_ready_wait: assert property ((psel && !penable) ##1 (psel && penable)
        |-> !pready ##1 pready) else $error("ready not after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_err_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("error read data not zero");
    chk_select_wait: assert property ($fell(cs_n_out) && cs_n_oe
        |-> $stable(sclk_out)[*2]) else $error("clock moved too soon after select");
    chk_word_edges: assert property ($rose(cs_n_out) && cs_n_oe
        |-> edges >= 7'h04 && edges <= 7'h20) else $error("clock edge count off");
    chk_master_clock: assert property (cs_n_oe && !cs_n_out
        |-> sclk_oe && simo_oe) else $error("master not driving clock");
    chk_master_listen: assert property (cs_n_oe && !cs_n_out
        |-> !somi_oe) else $error("master drives its input line");
    cover property (pslverr);
    cover property ($fell(cs_n_out) && cs_n_oe);
    cover property ($rose(cs_n_out) && edges > 7'h10);
endmodule : msp_properties

bind msp_serial_port msp_properties i_msp_properties (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .simo_oe(simo_oe), .somi_oe(somi_oe),
    .cs_n_out(cs_n_out), .cs_n_oe(cs_n_oe)
);

// [tb/msp_peer_model.sv]
// Behavioural external slave facing the serial port
`timescale 1ns/100ps
module msp_peer_model (
    // Pins from the far side
    input wire logic              cs_n,
    input wire logic              sclk,
    input wire logic              simo,
    output logic                  somi,
    // Per word: [5] phase, [4:0] length; idle clock low only
    input wire logic [1:0][5:0]   fmt,
    input wire logic [1:0][15:0]  reply,
    output logic     [1:0][15:0]  got
);
    logic       k;
    logic [4:0] n;
    initial begin
        somi = 1'b1;
        k    = 1'b1;
        got  = '0;
    end
    always @(negedge cs_n) begin
        k = ~k;
        n = fmt[k][4:0];
        got[k] = 16'h0000;
        if (!fmt[k][5]) begin
            n = n - 5'h01;
            somi = reply[k][n];
        end
    end
    always @(sclk) begin
        if (!cs_n) begin
            if (sclk ^ fmt[k][5])
                got[k] = {got[k][14:0], simo};
            else if (n != 5'h00) begin
                n = n - 5'h01;
                somi = reply[k][n];
            end
        end
    end
    // Released line must not look valid
    always @(posedge cs_n) somi = ~somi;
endmodule : msp_peer_model

// [tb/tb_top.sv]
// Self-checking bench for the multibuffered serial port
`timescale 1ns/100ps
module tb_top import msp_pkg::*;;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [12:0]      paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic             sclk_out, sclk_oe, simo_out, simo_oe, somi_out, somi_oe;
    logic             cs_n_out, cs_n_oe, sclk_drv, simo_drv, cs_n_drv, peer_somi;
    logic [1:0][5:0]  fmt;
    logic [1:0][15:0] txw, reply, got;
    int               n_errors, tests_run;
    wire sclk_w = sclk_oe ? sclk_out : sclk_drv;
    wire simo_w = simo_oe ? simo_out : simo_drv;
    wire somi_w = somi_oe ? somi_out : peer_somi;
    wire cs_n_w = cs_n_oe ? cs_n_out : cs_n_drv;

    msp_serial_port i_msp_serial_port (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_w), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .simo_in(simo_w), .simo_out(simo_out), .simo_oe(simo_oe),
        .somi_in(somi_w), .somi_out(somi_out), .somi_oe(somi_oe), .cs_n_in(cs_n_w),
        .cs_n_out(cs_n_out), .cs_n_oe(cs_n_oe)
    );
    msp_peer_model i_msp_peer_model (
        .cs_n(cs_n_w), .sclk(sclk_w), .simo(simo_w), .somi(peer_somi),
        .fmt(fmt), .reply(reply), .got(got)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask : check

    function automatic logic [12:0] ram(input int e, input int f);
        return {1'b1, e[7:0], f[1:0], 2'b00};
    endfunction : ram

    // Entered just after a rising edge; held until ready is sampled
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: no ready", $time);
        end
        // Idle cycle: results settle, next setup never reassigns psel at once
        @(posedge pclk);
    endtask : apb

    task automatic rd_chk(input logic [12:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        check(rd, e, m);
    endtask : rd_chk

    task automatic s_reset;
        check({28'h0, sclk_oe, simo_oe, somi_oe, cs_n_oe}, 32'h0, "pins driven");
        check({31'h0, cs_n_out}, 32'h1, "select level");
        rd_chk(OFF_CTRL, 32'h0, "control reset");
    endtask : s_reset

    task automatic s_ram;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ram(8'hff, i), 32'hffff0000 | (32'h1111 * (i + 1)));
        end
        apb(1'b1, ram(8'h00, FLD_TX), 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd_chk(ram(8'hff, i), 32'h1111 * (i + 1), "last entry field");
        end
        apb(1'b0, 13'h001c, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped flag");
        apb(1'b1, OFF_BAUD, 32'h1ff);
        rd_chk(OFF_BAUD, 32'hff, "divisor width");
    endtask : s_ram

    task automatic s_gpio;
        simo_drv <= 1'b0;
        apb(1'b1, OFF_GIO, 32'h0111);
        check({30'h0, sclk_out, sclk_oe}, 32'h3, "clock pin as output");
        apb(1'b0, OFF_GIN, 32'h0);
        check(rd & 32'hb, 32'h9, "pin inputs");
        apb(1'b1, OFF_GIO, 32'h0);
    endtask : s_gpio

    task automatic s_master(input logic hold, input logic [7:0] baud, dly, first, last);
        int          n;
        logic [4:0]  lm1;
        logic [15:0] m;
        apb(1'b1, OFF_CTRL, {29'h0, hold, 2'b11});
        apb(1'b1, OFF_BAUD, {24'h0, baud});
        apb(1'b1, OFF_DELAY, {24'h0, dly});
        apb(1'b1, OFF_GROUP, {16'h0, last, first});
        for (int i = 0; i <= last - first; i++) begin
            lm1 = fmt[i][4:0] - 5'h01;
            apb(1'b1, ram(first + i, FLD_TX), {16'h0, txw[i]});
            apb(1'b1, ram(first + i, FLD_CTL), {26'h0, fmt[i][5], 1'b0, lm1[3:0]});
        end
        apb(1'b1, OFF_CTRL, {28'h0, 1'b1, hold, 2'b11});
        n = 0;
        while (cs_n_out !== 1'b0 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (sclk_out === 1'b0 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n), 32'(dly) + (hold ? 32'(SEL_EXTRA_HOLD) : 32'(SEL_EXTRA)),
            "select to clock");
        n = 0;
        while (sclk_out === 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n), 32'(baud) + 32'h1, "half period");
        n = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0);
            n++;
        end while (rd[STAT_DONE] !== 1'b1 && n < 300);
        check({31'h0, rd[STAT_DONE]}, 32'h1, "group done");
        m = 16'hffff >> (16 - fmt[last - first][4:0]);
        check({16'h0, rd[31:16]}, {16'h0, reply[last - first] & m}, "receive buffer");
        for (int i = 0; i <= last - first; i++) begin
            m = 16'hffff >> (16 - fmt[i][4:0]);
            rd_chk(ram(first + i, FLD_RX), {16'h0, reply[i] & m}, "rx word");
            rd_chk(ram(first + i, FLD_STAT), 32'h1, "word status");
            check({16'h0, got[i]}, {16'h0, txw[i] & m}, "peer word");
        end
        apb(1'b1, OFF_STATUS, 32'h2);
        apb(1'b0, OFF_STATUS, 32'h0);
        check(rd & 32'h3, 32'h0, "done cleared");
    endtask : s_master

    // Far side clocks a 2-bit word into the port as slave
    task automatic s_slave;
        apb(1'b1, ram(0, FLD_TX), 32'h2);
        apb(1'b1, ram(0, FLD_CTL), 32'h1);
        apb(1'b1, OFF_GROUP, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h9);
        cs_n_drv <= 1'b0;
        simo_drv <= 1'b0;
        repeat (4) @(posedge pclk);
        check({31'h0, somi_w}, 32'h1, "slave first bit");
        sclk_drv <= 1'b1;
        repeat (3) @(posedge pclk);
        sclk_drv <= 1'b0;
        simo_drv <= 1'b1;
        repeat (3) @(posedge pclk);
        check({31'h0, somi_w}, 32'h0, "slave second bit");
        sclk_drv <= 1'b1;
        repeat (3) @(posedge pclk);
        sclk_drv <= 1'b0;
        repeat (4) @(posedge pclk);
        cs_n_drv <= 1'b1;
        rd_chk(ram(0, FLD_RX), 32'h1, "slave rx word");
    endtask : s_slave

    initial begin
        #(100 * 20000);
        n_errors++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {sclk_drv, simo_drv} = 2'b00;
        cs_n_drv = 1'b1;
        n_errors = 0;
        tests_run = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_reset();
        s_ram();
        s_gpio();
        fmt = {6'h22, 6'h10};
        txw = {16'h0002, 16'ha53c};
        reply = {16'h0001, 16'h3cc5};
        s_master(1'b0, 8'h01, 8'h03, 8'h10, 8'h11);
        fmt[0] = 6'h27;
        txw[0] = 16'h005a;
        reply[0] = 16'h0033;
        s_master(1'b1, 8'h00, 8'h00, 8'hff, 8'hff);
        s_slave();
        conclude();
    end
endmodule : tb_top
